//--- verif/ppl_port_pll_tb_top.sv
// Purpose: self-checking bench of the per-port dpll
// Assumes: slew window cut to 16 cycles, lock limits to 4 windows
// Notes:   pins run from free counters, not at exact nominal rates
`timescale 1ns/1ps
module ppl_port_pll_tb_top
  import ppl_pkg::*;
;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        loss_of_signal = 1'b0;
  logic        err;
  logic [2:0]  pins = 3'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, c, r, prdata;
  logic [63:0] rows [4];
  logic        ts_stb, pw_stb, pready, pslverr, svc, locked, hold;
  logic [4:0]  ts_data;
  logic [15:0] pw_data;
  int          tick = 0, num_errors = 0, checks_done = 0;
  function automatic logic [31:0] ctr(longint hz);
    ctr = 32'((hz * NCO_ONE + CLK_HZ / 2) / CLK_HZ);
  endfunction : ctr
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", nm, e, g);
      num_errors++;
    end
  endtask : chk
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic finish_test();
    if (num_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  ppl_port_pll #(.SLEW_CYC(16), .LOCK_LINE(4), .LOCK_STAMP(4),
    .LOCK_NET(4)) u_ppl_port_pll (
    .MCLK(mclk), .NRST(nrst), .CE(ce), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .LINE_CLK_IN(pins[0]),
    .NET_8K_IN(pins[1]), .FNX_TICK_IN(pins[2]), .LOS_IN(loss_of_signal),
    .TS_STB(ts_stb), .TS_DATA(ts_data), .PW_STB(pw_stb), .PW_DATA(pw_data),
    .SVC_CLK_OUT(svc), .LOCKED_OUT(locked), .HOLDOVER_OUT(hold));
  ppl_reasm u_ppl_reasm (.clk(mclk), .ts_stb(ts_stb), .ts_data(ts_data),
    .pw_stb(pw_stb), .pw_data(pw_data));
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  // line clock near 2 MHz, 8 kHz reference, stamp count clock
  always @(posedge mclk) begin
    tick <= tick + 1;
    pins <= {tick[2], (tick % 5000) < 2500, (tick % 20) < 10};
  end
  initial begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    finish_test();
  end
  initial begin
    rows = '{{32'h08, ctr(F_DS1_HZ)}, {32'h18, ctr(F_E1_HZ)},
             {32'h28, ctr(F_C4_HZ)}, {32'h38, ctr(F_E1_HZ)}};
    c = ctr(F_E1_HZ);
    r = 32'(longint'(c) * RNG_PPM / PPM);
    repeat (8) @(posedge mclk);
    chk("rst", 32'h0, {28'h0, hold, locked, pready, svc});
    nrst <= 1'b1;
    apb(1'b0, A_FTW, 32'h0);
    chk("rst_ftw", ctr(F_DS1_HZ), rd);
    // freerun at every rate: field read back, tuning word at centre
    foreach (rows[i]) begin
      apb(1'b1, A_CFG, rows[i][63:32]);
      apb(1'b0, A_CFG, 32'h0);
      chk("cfg", rows[i][63:32], rd);
      apb(1'b0, A_FTW, 32'h0);
      chk("ftw", rows[i][31:0], rd);
    end
    apb(1'b1, 8'h14, 32'hFFFF_FFFF);
    chk("bad_wr", 32'h1, err);
    apb(1'b0, 8'h14, 32'h0);
    chk("bad_rd", 32'h1, {rd[30:0], err});
    apb(1'b1, A_FTW, 32'h0);
    apb(1'b0, A_FTW, 32'h0);
    chk("ro_ftw", c, rd);
    // cpu offset: slewed, then reached, then clipped at locking range
    apb(1'b1, A_DCO, 32'h0000_9C40);
    apb(1'b1, A_CFG, 32'h1C);
    apb(1'b0, A_FTW, 32'h0);
    chk("slew", 32'h1, rd - c <= longint'(c) * SLEW_PPM / PPM);
    repeat (100) @(posedge mclk);
    apb(1'b0, A_FTW, 32'h0);
    chk("cpu_ftw", c + 32'h9C40, rd);
    apb(1'b1, A_DCO, 32'h000F_4240);
    repeat (200) @(posedge mclk);
    apb(1'b0, A_FTW, 32'h0);
    chk("cpu_sat", c + r, rd);
    apb(1'b1, A_CFG, 32'h14);
    repeat (40) @(posedge mclk);
    apb(1'b0, A_STAT, 32'h0);
    chk("hold_st", 32'h1, rd[1]);
    apb(1'b0, A_FTW, 32'h0);
    chk("hold_ftw", c + r, rd);
    apb(1'b1, A_CFG, 32'h18);
    repeat (200) @(posedge mclk);
    apb(1'b0, A_FTW, 32'h0);
    chk("free_back", c, rd);
    // clock enable low freezes the oscillator with all other state
    ce <= 1'b0;
    repeat (2) @(posedge mclk);
    rd = {31'h0, svc};
    repeat (30) @(posedge mclk);
    chk("ce_hold", rd, {31'h0, svc});
    ce <= 1'b1;
    // adaptive: neutral words leave the rate, a fill above average moves it
    apb(1'b1, A_CFG, 32'h13);
    repeat (3) u_ppl_reasm.phase(16'h0000);
    repeat (40) @(posedge mclk);
    apb(1'b0, A_FTW, 32'h0);
    chk("pw_idle", c, rd);
    chk("pw_lock", 32'h1, locked);
    repeat (4) u_ppl_reasm.phase(16'h4000);
    repeat (80) @(posedge mclk);
    apb(1'b0, A_FTW, 32'h0);
    chk("pw_steer", 32'h1, rd != c);
    // host as loop filter: read the filter, write back a correction
    apb(1'b0, A_FILT, 32'h0);
    r = rd + 32'h0000_1000;
    apb(1'b1, A_DCO, r);
    apb(1'b1, A_CFG, 32'h1F);
    repeat (40) @(posedge mclk);
    apb(1'b0, A_FTW, 32'h0);
    chk("cpu_loop", c + r, rd);
    // loss of signal holds only in unstructured transport
    apb(1'b1, A_CFG, 32'h10);
    loss_of_signal <= 1'b1;
    repeat (8) @(posedge mclk);
    chk("los_sdt", 32'h0, hold);
    apb(1'b1, A_CFG, 32'h50);
    repeat (8) @(posedge mclk);
    chk("los_udt", 32'h1, hold);
    loss_of_signal <= 1'b0;
    apb(1'b1, A_CFG, 32'h11);
    repeat (8) @(posedge mclk);
    chk("ts_pre", 32'h0, hold);
    u_ppl_reasm.stamp(1'b1, 4'h3);
    #1 chk("ts_bad", 32'h1, hold);
    // network mode with no reference edge: lock timeout, then clear
    apb(1'b1, A_CFG, 32'h12);
    repeat (100) @(posedge mclk);
    apb(1'b0, A_STAT, 32'h0);
    chk("net_lto", 32'h4, rd);
    apb(1'b1, A_CFG, 32'h1A);
    apb(1'b1, A_STAT, 32'h4);
    apb(1'b0, A_STAT, 32'h0);
    chk("lto_clr", 32'h0, rd);
    // second reset mid-run: outputs and config back to defaults
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("rst2", 32'h0, {28'h0, hold, locked, pready, svc});
    nrst <= 1'b1;
    apb(1'b0, A_CFG, 32'h0);
    chk("rst2_cfg", 32'h0, rd);
    finish_test();
  end
endmodule : ppl_port_pll_tb_top
bind ppl_port_pll ppl_props u_ppl_props (.MCLK, .NRST, .CE, .PSEL,
  .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
  .LOS_IN, .TS_STB, .TS_DATA, .SVC_CLK_OUT, .HOLDOVER_OUT);

//--- verif/ppl_props.sv
// Purpose: port checks of the per-port dpll
// Assumes: one clock; cfg shadowed from committed apb writes
// Notes:   level runs assume the slowest rate, 1.544 MHz
`timescale 1ns/1ps
module ppl_props
  import ppl_pkg::*;
(
  input wire logic        MCLK,
  input wire logic        NRST,
  input wire logic        CE,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        LOS_IN,
  input wire logic        TS_STB,
  input wire logic [4:0]  TS_DATA,
  input wire logic        SVC_CLK_OUT,
  input wire logic        HOLDOVER_OUT
);
  logic [6:0] cfg_reg;
  logic [4:0] run_reg;
  logic       acc;
  logic       bad;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!NRST);
  // first access cycle of a request, and whether its address is mapped
  assign acc = PSEL && PENABLE && !PREADY && CE;
  assign bad = !(PADDR inside {A_CFG, A_DCO, A_FILT, A_STAT, A_FTW});
  // cfg copy taken where the write lands; run length of the svc level
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      cfg_reg <= '0;
      run_reg <= '0;
    end else begin
      if (CE && PSEL && PENABLE && PREADY && PWRITE && PADDR == A_CFG)
        cfg_reg <= PWDATA[6:0];
      run_reg <= (!CE || $changed(SVC_CLK_OUT)) ? 5'h00 : run_reg + 5'h01;
    end
  end
  pready_pulse_a:
    assert property (PREADY && CE |=> !PREADY) else $error("ready held");
  pready_wait_a:
    assert property (acc |=> PREADY) else $error("ready late");
  err_bad_a:
    assert property (acc && bad |=> PSLVERR && PRDATA == 32'h0)
      else $error("unmapped not refused");
  err_ok_a:
    assert property (acc && !bad |=> !PSLVERR) else $error("mapped refused");
  hold_mode_a:
    assert property ((CE && cfg_reg[3:2] == SM_HOLD) [*3] |-> HOLDOVER_OUT)
      else $error("no holdover by mode");
  hold_los_a:
    assert property ((CE && LOS_IN && cfg_reg[6] && cfg_reg[3:2] == SM_NORM)
      [*6] |-> HOLDOVER_OUT) else $error("no holdover on los");
  hold_stamp_a:
    assert property (CE && TS_STB && TS_DATA[4] && cfg_reg[3:0] == 4'h1
      |=> HOLDOVER_OUT) else $error("no holdover on bad stamp");
  svc_run_a:
    assert property (run_reg <= 5'h0D) else $error("service clock stalled");
endmodule : ppl_props

//--- verif/ppl_reasm.sv
// Purpose: reassembly side model feeding stamps and phasewords
// Assumes: strobes are one-cycle pulses on the master clock
// Notes:   data lines carry the inverse of the last word between strobes
`timescale 1ns/1ps
module ppl_reasm (
  input  wire logic        clk,
  output logic             ts_stb,
  output logic [4:0]       ts_data,
  output logic             pw_stb,
  output logic [15:0]      pw_data
);
  // idle strobes; phaseword neutral from start so nothing is steered
  initial begin
    ts_stb = 1'b0;
    ts_data = 5'h0F;
    pw_stb = 1'b0;
    pw_data = 16'h0000;
  end
  // one stamp; top bit marks a consumed or lost entry
  task automatic stamp(input logic bad, input logic [3:0] nib);
    @(posedge clk);
    ts_stb <= 1'b1;
    ts_data <= {bad, nib};
    @(posedge clk);
    ts_stb <= 1'b0;
    ts_data <= ~{bad, nib};
  endtask : stamp
  // one fill-level word, zero when the buffer sits at average
  task automatic phase(input logic [15:0] w);
    @(posedge clk);
    pw_stb <= 1'b1;
    pw_data <= w;
    @(posedge clk);
    pw_stb <= 1'b0;
    pw_data <= ~w;
  endtask : phase
endmodule : ppl_reasm

//--- verilog/ppl_pkg.sv
// Purpose: shared constants, types and helpers of the per-port DPLL
// Assumes: 40 MHz master clock, 32-bit numerically controlled oscillator
// Notes:   all tuning words derived here from the clock rate
package ppl_pkg;

  localparam longint CLK_HZ   = 40_000_000;
  localparam longint CLK_NS   = 25;
  localparam longint NCO_ONE  = 64'h1_0000_0000;   // 2^32
  localparam longint F_DS1_HZ = 1_544_000;
  localparam longint F_E1_HZ  = 2_048_000;
  localparam longint F_C4_HZ  = 4_096_000;
  localparam longint PPM      = 1_000_000;
  localparam longint RNG_PPM  = 246;               // 8k, 2.048, 4.096 refs
  localparam longint RNG1_PPM = 245;               // 1.544 ref
  localparam longint SLEW_PPM = 61;

  // apb register byte addresses
  localparam logic [7:0] A_CFG  = 8'h00;
  localparam logic [7:0] A_DCO  = 8'h04;
  localparam logic [7:0] A_FILT = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0C;
  localparam logic [7:0] A_FTW  = 8'h10;
  localparam int F_UDT   = 6;                      // cfg: unstructured bit
  localparam int S_LOCK  = 0;
  localparam int S_HOLD  = 1;
  localparam int S_LTO   = 2;

  // slew window and lock-time limits
  localparam longint SLEW_WIN_NS = 1_326_000;      // 1.326 ms
  localparam longint SLEW_CYC_DEF = SLEW_WIN_NS / CLK_NS;
  localparam longint NS_PER_S = 1_000_000_000;
  localparam longint LOCK_LINE_S  = 15;
  localparam longint LOCK_STAMP_S = 100;
  localparam longint LOCK_NET_S   = 40;

  localparam logic signed [7:0] PD_MAX   = 8'sh10; // +/-16 UI detector
  localparam logic signed [7:0] LOCK_TOL = 8'sh01;
  localparam logic [11:0] STAMP_BITS = 12'hBB8;     // 3000 bits per stamp
  localparam int KP_SH = 6;
  localparam int KI_SH = 2;

  typedef enum logic [1:0] {
    IN_LINE  = 2'b00, IN_STAMP = 2'b01, IN_NET = 2'b10, IN_ADAPT = 2'b11
  } ppl_isel_t;
  typedef enum logic [1:0] {
    SM_NORM = 2'b00, SM_HOLD = 2'b01, SM_FREE = 2'b10, SM_CPU = 2'b11
  } ppl_smode_t;
  typedef enum logic [1:0] {
    R_DS1 = 2'b00, R_E1 = 2'b01, R_C4 = 2'b10, R_RSV = 2'b11
  } ppl_rate_t;

  typedef struct packed {
    logic [2:0]  ls, ns, fs;      // pin synchronisers plus edge stage
    logic [1:0]  loss_of_signal;
    ppl_isel_t   isel;
    ppl_smode_t  smode;
    ppl_rate_t   rate;
    logic        unstructured_transport;
    logic [31:0] dco, nco, integ, off, filt;
    logic [7:0]  pd;
    logic [9:0]  ocnt;
    logic [11:0] scnt;
    logic [3:0]  fnx, lst;
    logic [16:0] win, ltim;
    logic        ts_bad, hold, locked, lto, rdy, err;
    logic [31:0] rd;
  } ppl_st_t;
  localparam ppl_st_t PPL_ST_RST = '0;

  function automatic longint hz_of(ppl_rate_t r);
    unique case (r)
      R_DS1:   hz_of = F_DS1_HZ;
      R_C4:    hz_of = F_C4_HZ;
      default: hz_of = F_E1_HZ;
    endcase
  endfunction : hz_of

  // rounded tuning word of the nominal centre frequency
  function automatic logic [31:0] center(ppl_rate_t r);
    center = 32'((hz_of(r) * NCO_ONE + CLK_HZ / 2) / CLK_HZ);
  endfunction : center

  function automatic logic [31:0] lock_rng(ppl_rate_t r);
    longint p;
    p = (r == R_DS1) ? RNG1_PPM : RNG_PPM;
    lock_rng = 32'((longint'(center(r)) * p) / PPM);
  endfunction : lock_rng

  function automatic logic [31:0] slew_step(ppl_rate_t r);
    slew_step = 32'((longint'(center(r)) * SLEW_PPM) / PPM);
  endfunction : slew_step

  // unit intervals in one 125 us frame
  function automatic logic [9:0] frame_ui(ppl_rate_t r);
    frame_ui = 10'(hz_of(r) / 8000);
  endfunction : frame_ui

  // saturate a signed value to +/- lim
  function automatic logic [31:0] sat(logic signed [33:0] v,
                                      logic [31:0] lim);
    logic signed [33:0] l;
    l = $signed({2'b00, lim});
    if (v > l)       sat = lim;
    else if (v < -l) sat = 32'(-l);
    else             sat = v[31:0];
  endfunction : sat

endpackage : ppl_pkg

//--- verilog/ppl_port_pll.sv
// Purpose: one port's digital PLL with mode and sub-mode control
// Assumes: APB slave registers, pins synchronised on MCLK
// Notes:   stamp and phaseword strobes come from logic on MCLK
//
// Function
// - line mode locks service clock phase to port line clock input.
// - line mode lock reached within about 15 seconds.
// - stamp mode compares received stamps against locally generated stamps.
// - stamp mode lock reached within about 100 seconds.
// - network mode locks to 8 kHz reference from network clock divider.
// - network mode lock reached within about 40 seconds.
// - adaptive mode steers rate from reassembly buffer fill phaseword.
// - rate-select field picks 1.544, 2.048 or 4.096 MHz centre.
// - input-select picks reference; sub-mode picks normal/hold/free/cpu.
// - holdover by sub-mode or loss of signal in unstructured; offset frozen in normal and hold sub-modes.
// - freerun ignores input and outputs the nominal centre frequency from the rounded tuning word.
// - cpu sub-mode takes oscillator offset from host difference register.
// - freerun accuracy near 0.1 ppm, locking range near 250 ppm.
// - phase detector spans 32 UI peak-to-peak, plus or minus 16.
// - intrinsic jitter under half a master clock period; the nco output edge here jitters by one MCLK.
// - oscillator input slews at most 61 ppm per 1.326 ms window.
// - offset limited to 246 ppm, or 245 ppm for 1.544 MHz.
// - locking range is relative to the master clock.
// - neutral phaseword leaves clock unadjusted; slip presets steer it.
// - invalid time stamp forces automatic holdover.
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
module ppl_port_pll
  import ppl_pkg::*;
#(
  parameter int SLEW_CYC   = int'(SLEW_CYC_DEF),
  parameter int LOCK_LINE  = int'(LOCK_LINE_S * NS_PER_S / SLEW_WIN_NS),
  parameter int LOCK_STAMP = int'(LOCK_STAMP_S * NS_PER_S / SLEW_WIN_NS),
  parameter int LOCK_NET   = int'(LOCK_NET_S * NS_PER_S / SLEW_WIN_NS)
) (
  input  wire logic        MCLK,
  input  wire logic        NRST,
  input  wire logic        CE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        LINE_CLK_IN,
  input  wire logic        NET_8K_IN,
  input  wire logic        FNX_TICK_IN,
  input  wire logic        LOS_IN,
  input  wire logic        TS_STB,
  input  wire logic [4:0]  TS_DATA,
  input  wire logic        PW_STB,
  input  wire logic [15:0] PW_DATA,
  output logic             SVC_CLK_OUT,
  output logic             LOCKED_OUT,
  output logic             HOLDOVER_OUT
);

  ppl_st_t            s;
  ppl_st_t            n;
  logic [31:0]        nco_sum;
  logic               orise;
  logic               lrise;
  logic               nrise;
  logic               frise;
  logic               ev;
  logic signed [7:0]  e;
  logic signed [8:0]  t9;
  logic signed [33:0] v;
  logic signed [10:0] d11;
  logic [31:0]        tgt;
  logic [31:0]        rng;
  logic [31:0]        stp;
  logic               wrap;
  logic               hold;
  logic               acc;
  logic               hit;
  logic [16:0]        lim;

  always_comb begin
    n     = s;
    rng   = lock_rng(s.rate);
    stp   = slew_step(s.rate);
    ev    = 1'b0;
    e     = '0;
    t9    = '0;
    v     = '0;
    d11   = '0;
    tgt   = s.off;
    lim   = '0;
    // pins pass two flops; edge taken from second and third stage
    n.ls  = {s.ls[1:0], LINE_CLK_IN};
    n.ns  = {s.ns[1:0], NET_8K_IN};
    n.fs  = {s.fs[1:0], FNX_TICK_IN};
    n.loss_of_signal = {s.loss_of_signal[0], LOS_IN};
    lrise = s.ls[1] & ~s.ls[2];
    nrise = s.ns[1] & ~s.ns[2];
    frise = s.fs[1] & ~s.fs[2];

    // nco: output edge jitter is one MCLK, msb rising 0 to 1 decides edge
    nco_sum = s.nco + center(s.rate) + s.off;
    n.nco   = nco_sum;
    orise   = nco_sum[31] & ~s.nco[31];

    // phase detectors, one per reference kind
    unique case (s.isel)
      IN_LINE: begin
        t9 = 9'($signed(s.pd)) + 9'(lrise) - 9'(orise);
        if (t9 > 9'(PD_MAX)) t9 = 9'(PD_MAX);
        if (t9 < -9'(PD_MAX)) t9 = -9'(PD_MAX);
        n.pd = t9[7:0];
        ev   = lrise;
        e    = t9[7:0];
      end
      IN_NET: begin
        n.ocnt = s.ocnt + 10'(orise);
        if (nrise) begin
          // clamp at full width so a large count error cannot wrap
          d11 = $signed({1'b0, frame_ui(s.rate)}) - $signed({1'b0, s.ocnt});
          if (d11 > 11'(PD_MAX)) d11 = 11'(PD_MAX);
          if (d11 < -11'(PD_MAX)) d11 = -11'(PD_MAX);
          t9 = d11[8:0];
          ev     = 1'b1;
          e      = t9[7:0];
          n.ocnt = 10'(orise);
        end
      end
      IN_STAMP: begin
        // local stamp: network ticks counted per 3000 service bits
        n.fnx = s.fnx + 4'(frise);
        if (orise) begin
          n.scnt = (s.scnt == STAMP_BITS - 12'h001) ? '0
                 : s.scnt + 12'h001;
          if (s.scnt == STAMP_BITS - 12'h001) n.lst = s.fnx;
        end
        if (TS_STB) begin
          n.ts_bad = TS_DATA[4];
          ev       = ~TS_DATA[4];
          e        = 8'($signed(s.lst - TS_DATA[3:0]));
        end
      end
      IN_ADAPT: begin
        // zero phaseword is neutral; slip presets sit at the extremes
        ev = PW_STB;
        e  = PW_DATA[15:8];
      end
    endcase

    // holdover sources; an invalid stamp holds until a valid one
    hold = (s.smode == SM_HOLD) | (s.loss_of_signal[1] & s.unstructured_transport)
         | ((s.isel == IN_STAMP) & n.ts_bad);
    n.hold = hold;

    // pi loop filter, integrator clamped to the lock range
    if (ev & (s.smode == SM_NORM) & ~hold) begin
      v       = $signed(s.integ) + (34'(e) <<< KI_SH);
      n.integ = sat(v, rng);
      v       = $signed(n.integ) + (34'(e) <<< KP_SH);
      n.filt  = sat(v, rng);
    end

    // oscillator offset target per sub-mode
    unique case (s.smode)
      SM_NORM: tgt = hold ? s.off : s.filt;
      SM_HOLD: tgt = s.off;
      SM_FREE: tgt = '0;
      SM_CPU:  tgt = sat(34'($signed(s.dco)), rng);
    endcase

    // slew limiter: offset moves one bounded step per window
    wrap  = (s.win == 17'(SLEW_CYC - 1));
    n.win = wrap ? '0 : s.win + 17'h00001;
    if (wrap) begin
      v = $signed({2'b00, tgt}) - $signed({2'b00, s.off});
      v = {v[31], v[31], v[31:0]};                          // 32-bit diff
      n.off = s.off + sat(v, stp);
    end

    // lock detect and lock-time supervision
    if ((s.smode != SM_NORM) | hold) n.locked = 1'b0;
    else if (ev) n.locked = (e <= LOCK_TOL) & (e >= -LOCK_TOL);
    unique case (s.isel)
      IN_LINE:  lim = 17'(LOCK_LINE);
      IN_STAMP: lim = 17'(LOCK_STAMP);
      IN_NET:   lim = 17'(LOCK_NET);
      IN_ADAPT: lim = '0;
    endcase
    if (s.locked | (s.smode != SM_NORM) | hold) n.ltim = '0;
    else if (wrap & (s.ltim != 17'h1FFFF)) n.ltim = s.ltim + 17'h00001;

    // apb: one wait state, write lands on the completing edge
    acc = PSEL & PENABLE;
    hit = (PADDR == A_CFG) | (PADDR == A_DCO) | (PADDR == A_FILT)
        | (PADDR == A_STAT) | (PADDR == A_FTW);
    n.rdy = acc & ~s.rdy;
    if (acc & ~s.rdy) begin
      n.err = ~hit;
      unique case (PADDR)
        A_CFG:   n.rd = {25'h0000000, s.unstructured_transport, s.rate, s.smode, s.isel};
        A_DCO:   n.rd = s.dco;
        A_FILT:  n.rd = s.filt;
        A_STAT:  n.rd = {29'h00000000, s.lto, s.hold, s.locked};
        A_FTW:   n.rd = center(s.rate) + s.off;
        default: n.rd = '0;
      endcase
    end
    if (acc & s.rdy & PWRITE & ~s.err) begin
      unique case (PADDR)
        A_CFG: begin
          // live reconfiguration; detector restarts on a new input
          n.isel  = ppl_isel_t'(PWDATA[1:0]);
          n.smode = ppl_smode_t'(PWDATA[3:2]);
          n.rate  = ppl_rate_t'(PWDATA[5:4]);
          n.unstructured_transport   = PWDATA[F_UDT];
          if (PWDATA[1:0] != s.isel) begin
            n.pd     = '0;
            n.ocnt   = '0;
            n.scnt   = '0;
            n.ts_bad = 1'b0;
            n.locked = 1'b0;
            n.ltim   = '0;
            n.integ  = s.off;                        // bumpless
            n.filt   = s.off;
          end
        end
        A_DCO:  n.dco = PWDATA;
        A_STAT: if (PWDATA[S_LTO]) n.lto = 1'b0;
        default: n.dco = s.dco;
      endcase
    end
    // timeout flag set after the clear so a same-cycle event wins
    if ((lim != '0) & (s.ltim >= lim)) n.lto = 1'b1;
  end

  // one register for all state; reset gives centre frequency
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      s <= PPL_ST_RST;
    end else if (CE) begin
      s <= n;
    end
  end

  // outputs straight from flops; PSLVERR is s.err gated by s.rdy
  assign PRDATA       = s.rd;
  assign PREADY       = s.rdy;
  assign PSLVERR      = s.err & s.rdy;
  assign SVC_CLK_OUT  = s.nco[31];
  assign LOCKED_OUT   = s.locked;
  assign HOLDOVER_OUT = s.hold;

endmodule : ppl_port_pll
